// *** core/pair_ready_pkg.sv ***
`default_nettype none
package pair_ready_pkg;
  localparam int NUM_PAIRS = 13;
  localparam int REG_W = 16;
  localparam int ADDR_W = 4;
  localparam int IDX_W = 4;
  localparam int NUM_PINS = 16;
  // Register offsets (word index on the plain port)
  localparam logic [3:0] OFS_PAIR_READY_STATUS = 4'h0;
  localparam logic [3:0] OFS_JUMP_TABLE_VECTOR_BASE = 4'h1;
  localparam logic [3:0] OFS_PIN_ANALOG_DIGITAL_SELECT = 4'h2;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h3;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h4;
  // Field layout
  localparam int IDX_SHIFT = 2;
  localparam logic [15:0] BASE_WR_MASK = 16'hfffe;
  localparam logic [15:0] STATUS_RD_MASK = 16'h1fff;
  // Reset values
  localparam logic [15:0] BASE_RESET = 16'h0000;
  localparam logic [15:0] PIN_DIGITAL_SELECT_BITS_RESET = 16'h0000;
  localparam logic [12:0] READY_RESET = 13'h0000;
  localparam logic [12:0] MASK_RESET = 13'h0000;
  localparam logic [15:0] READ_IDLE = 16'h0000;
endpackage
`default_nettype wire

// *** core/ready_priority_encoder.sv ***
`timescale 1ns/1ns
`default_nettype none
// Lowest set bit number wins; pair zero has the top priority
module ready_priority_encoder (
  input wire logic [12:0] ready_i,
  output logic [3:0] index_o,
  output logic any_o
);
  always_comb begin
    index_o = 4'h0;
    any_o = 1'b0;
    for (int i = pair_ready_pkg::NUM_PAIRS - 1; i >= 0; i--) begin
      if (ready_i[i]) begin
        index_o = 4'(i);
        any_o = 1'b1;
      end
    end
  end
endmodule // ready_priority_encoder
`default_nettype wire

// *** core/adc_pair_ready_vector_portcfg.sv ***
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module adc_pair_ready_vector_portcfg (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic [12:0] pair_done_i,
  output logic [12:0] pair_complete_irq_o,
  output logic [15:0] pin_digital_en_o,
  output logic [15:0] mux_to_analog_ground_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [12:0] ready_r;
  logic [15:0] base_r;
  logic [15:0] pin_digital_select_bits_r;
  logic [12:0] irq_stat_r;
  logic [12:0] irq_mask_r;
  logic [3:0] enc_idx;
  logic enc_any;
  logic [15:0] vector_value;
  logic wr_status, wr_base, wr_pin_digital_select_bits, wr_istat, wr_imask;

  assign wr_status = wr_i && (addr_i == pair_ready_pkg::OFS_PAIR_READY_STATUS);
  assign wr_base = wr_i && (addr_i == pair_ready_pkg::OFS_JUMP_TABLE_VECTOR_BASE);
  assign wr_pin_digital_select_bits = wr_i && (addr_i == pair_ready_pkg::OFS_PIN_ANALOG_DIGITAL_SELECT);
  assign wr_istat = wr_i && (addr_i == pair_ready_pkg::OFS_IRQ_STATUS);
  assign wr_imask = wr_i && (addr_i == pair_ready_pkg::OFS_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Ready flags: set wins over a written zero
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ready_r <= pair_ready_pkg::READY_RESET;
    end else if (wr_status) begin
      ready_r <= (ready_r & wdata_i[12:0]) | pair_done_i;
    end else begin
      ready_r <= ready_r | pair_done_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      base_r <= pair_ready_pkg::BASE_RESET;
    end else if (wr_base) begin
      base_r <= wdata_i & pair_ready_pkg::BASE_WR_MASK;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_digital_select_bits_r <= pair_ready_pkg::PIN_DIGITAL_SELECT_BITS_RESET;
    end else if (wr_pin_digital_select_bits) begin
      pin_digital_select_bits_r <= wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin mode outputs
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_digital_en_o <= pair_ready_pkg::PIN_DIGITAL_SELECT_BITS_RESET;
      mux_to_analog_ground_o <= pair_ready_pkg::PIN_DIGITAL_SELECT_BITS_RESET;
    end else begin
      pin_digital_en_o <= pin_digital_select_bits_r;
      mux_to_analog_ground_o <= pin_digital_select_bits_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pair completion pulses and summary interrupt
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pair_complete_irq_o <= pair_ready_pkg::READY_RESET;
    end else begin
      pair_complete_irq_o <= pair_done_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_stat_r <= pair_ready_pkg::READY_RESET;
    end else if (wr_istat) begin
      irq_stat_r <= (irq_stat_r & ~wdata_i[12:0]) | pair_done_i;
    end else begin
      irq_stat_r <= irq_stat_r | pair_done_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_mask_r <= pair_ready_pkg::MASK_RESET;
    end else if (wr_imask) begin
      irq_mask_r <= wdata_i[12:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vector computation
  ready_priority_encoder u_enc (
    .ready_i(ready_r),
    .index_o(enc_idx),
    .any_o(enc_any)
  );

  // Live flags feed the sum
  assign vector_value = base_r + (16'(enc_idx) << pair_ready_pkg::IDX_SHIFT);

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= pair_ready_pkg::READ_IDLE;
    end else if (rd_i) begin
      case (addr_i)
        pair_ready_pkg::OFS_PAIR_READY_STATUS:
          rdata_o <= {3'h0, ready_r} & pair_ready_pkg::STATUS_RD_MASK;
        pair_ready_pkg::OFS_JUMP_TABLE_VECTOR_BASE:
          rdata_o <= vector_value;
        pair_ready_pkg::OFS_PIN_ANALOG_DIGITAL_SELECT:
          rdata_o <= pin_digital_select_bits_r;
        pair_ready_pkg::OFS_IRQ_STATUS:
          rdata_o <= {3'h0, irq_stat_r};
        pair_ready_pkg::OFS_IRQ_MASK:
          rdata_o <= {3'h0, irq_mask_r};
        default:
          rdata_o <= pair_ready_pkg::READ_IDLE;
      endcase
    end else begin
      rdata_o <= pair_ready_pkg::READ_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_ready_set;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      pair_done_i[0] |=> ready_r[0];
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready flag not set");

  property p_ready_clear;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      wr_status && !wdata_i[0] && !pair_done_i[0] |=> !ready_r[0];
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready flag not cleared");

  property p_ready_hold;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      ready_r[3] && !(wr_status && !wdata_i[3]) |=> ready_r[3];
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready flag lost");

  property p_status_top_zero;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      rd_i && addr_i == pair_ready_pkg::OFS_PAIR_READY_STATUS |=> rdata_o[15:13] == 3'h0;
  endproperty
  a_status_top_zero: assert property (p_status_top_zero) else $error("status top bits");

  property p_base_lsb;
    @(posedge ref_clk_i) disable iff (!reset_n_i) base_r[0] == 1'b0;
  endproperty
  a_base_lsb: assert property (p_base_lsb) else $error("base bit zero set");

  property p_vector_read;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      rd_i && addr_i == pair_ready_pkg::OFS_JUMP_TABLE_VECTOR_BASE && ready_r[0]
      |=> rdata_o == $past(base_r);
  endproperty
  a_vector_read: assert property (p_vector_read) else $error("vector pair zero");

  property p_vector_prio;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      rd_i && addr_i == pair_ready_pkg::OFS_JUMP_TABLE_VECTOR_BASE && ready_r[2:0] == 3'h4
      |=> rdata_o == $past(base_r) + 16'h0008;
  endproperty
  a_vector_prio: assert property (p_vector_prio) else $error("vector priority");

  property p_vector_lsbs;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      rd_i && addr_i == pair_ready_pkg::OFS_JUMP_TABLE_VECTOR_BASE
      |=> rdata_o[1:0] == $past(base_r[1:0]);
  endproperty
  a_vector_lsbs: assert property (p_vector_lsbs) else $error("vector low bits");

  property p_pin_mode;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      wr_pin_digital_select_bits ##1 !wr_pin_digital_select_bits |=> pin_digital_en_o == $past(wdata_i, 2);
  endproperty
  a_pin_mode: assert property (p_pin_mode) else $error("pin mode");

  property p_pair_irq;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      pair_done_i[5] |=> pair_complete_irq_o[5];
  endproperty
  a_pair_irq: assert property (p_pair_irq) else $error("pair irq");

  property p_ready_set_top;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      pair_done_i[12] |=> ready_r[12];
  endproperty
  a_ready_set_top: assert property (p_ready_set_top) else $error("top ready flag");

  property p_ready_keep;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      wr_status && wdata_i[0] && ready_r[0] |=> ready_r[0];
  endproperty
  a_ready_keep: assert property (p_ready_keep) else $error("ready flag dropped");

  property p_ready_quiet;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      !pair_done_i[4] && !ready_r[4] |=> !ready_r[4];
  endproperty
  a_ready_quiet: assert property (p_ready_quiet) else $error("ready flag rose");

  property p_status_read;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      rd_i && addr_i == pair_ready_pkg::OFS_PAIR_READY_STATUS
      |=> rdata_o[12:0] == $past(ready_r);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read");

  property p_base_write;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      wr_base |=> base_r[15:1] == $past(wdata_i[15:1]);
  endproperty
  a_base_write: assert property (p_base_write) else $error("base write");

  property p_base_keep;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      !wr_base |=> $stable(base_r);
  endproperty
  a_base_keep: assert property (p_base_keep) else $error("base changed");

  property p_vector_none;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      rd_i && addr_i == pair_ready_pkg::OFS_JUMP_TABLE_VECTOR_BASE && ready_r == 13'h0000
      |=> rdata_o == $past(base_r);
  endproperty
  a_vector_none: assert property (p_vector_none) else $error("vector no flags");

  property p_vector_last;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      rd_i && addr_i == pair_ready_pkg::OFS_JUMP_TABLE_VECTOR_BASE && ready_r == 13'h1000
      |=> rdata_o == $past(base_r) + 16'h0030;
  endproperty
  a_vector_last: assert property (p_vector_last) else $error("vector last pair");

  property p_vector_step;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      rd_i && addr_i == pair_ready_pkg::OFS_JUMP_TABLE_VECTOR_BASE
      |=> rdata_o - $past(base_r) <= 16'h0030;
  endproperty
  a_vector_step: assert property (p_vector_step) else $error("vector offset");

  property p_vector_idx_low;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      rd_i && addr_i == pair_ready_pkg::OFS_JUMP_TABLE_VECTOR_BASE
      |=> ((rdata_o - $past(base_r)) & 16'h0003) == 16'h0000;
  endproperty
  a_vector_idx_low: assert property (p_vector_idx_low) else $error("index low bits");

  property p_sel_read;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      rd_i && addr_i == pair_ready_pkg::OFS_PIN_ANALOG_DIGITAL_SELECT
      |=> rdata_o == $past(pin_digital_select_bits_r);
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("select read");

  property p_pin_digital;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      pin_digital_select_bits_r[15] |=> pin_digital_en_o[15] && mux_to_analog_ground_o[15];
  endproperty
  a_pin_digital: assert property (p_pin_digital) else $error("pin not digital");

  property p_pin_analog;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      !pin_digital_select_bits_r[0] |=> !pin_digital_en_o[0] && !mux_to_analog_ground_o[0];
  endproperty
  a_pin_analog: assert property (p_pin_analog) else $error("pin not analog");

  property p_pin_follow;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      wr_pin_digital_select_bits |=> ##1 mux_to_analog_ground_o == $past(wdata_i, 2);
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("mux ground");

  property p_pair_irq_quiet;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      !pair_done_i[5] |=> !pair_complete_irq_o[5];
  endproperty
  a_pair_irq_quiet: assert property (p_pair_irq_quiet) else $error("pair irq stuck");

  property p_pair_irq_top;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      pair_done_i[12] |=> pair_complete_irq_o[12];
  endproperty
  a_pair_irq_top: assert property (p_pair_irq_top) else $error("top pair irq");

  property p_istat_set;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      pair_done_i[7] |=> irq_stat_r[7];
  endproperty
  a_istat_set: assert property (p_istat_set) else $error("irq status set");

  property p_istat_clear;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      wr_istat && wdata_i[7] && !pair_done_i[7] |=> !irq_stat_r[7];
  endproperty
  a_istat_clear: assert property (p_istat_clear) else $error("irq status clear");

  property p_irq_on;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      |(irq_stat_r & irq_mask_r) |=> irq_o;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq low");

  property p_irq_off;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      !(|(irq_stat_r & irq_mask_r)) |=> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq high");

  c_vector_read: cover property (@(posedge ref_clk_i)
    rd_i && addr_i == pair_ready_pkg::OFS_JUMP_TABLE_VECTOR_BASE && enc_any);
  c_clear: cover property (@(posedge ref_clk_i) wr_status && |ready_r);
  c_irq: cover property (@(posedge ref_clk_i) irq_o);
  c_set_wins: cover property (@(posedge ref_clk_i)
    wr_status && |(pair_done_i & ~wdata_i[12:0]));
  c_pin_digital: cover property (@(posedge ref_clk_i) pin_digital_en_o[15]);

endmodule // adc_pair_ready_vector_portcfg
`default_nettype wire

// *** tb/adc_pair_ready_vector_portcfg_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module adc_pair_ready_vector_portcfg_test;
  localparam logic [3:0] A_ST = pair_ready_pkg::OFS_PAIR_READY_STATUS;
  localparam logic [3:0] A_BASE = pair_ready_pkg::OFS_JUMP_TABLE_VECTOR_BASE;
  localparam logic [3:0] A_SEL = pair_ready_pkg::OFS_PIN_ANALOG_DIGITAL_SELECT;
  localparam logic [3:0] A_IRQ = pair_ready_pkg::OFS_IRQ_STATUS;
  localparam logic [3:0] A_MSK = pair_ready_pkg::OFS_IRQ_MASK;
  logic ref_clk, reset_n, wr, rd, irq;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, pin_en, mux_gnd, d, s, b;
  logic [12:0] pair_done, pair_irq, rdy, irqs, msk, v;
  int mismatches, n_tests;
  adc_pair_ready_vector_portcfg u_adc_pair_ready_vector_portcfg (
    .ref_clk_i(ref_clk), .reset_n_i(reset_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pair_done_i(pair_done),
    .pair_complete_irq_o(pair_irq), .pin_digital_en_o(pin_en),
    .mux_to_analog_ground_o(mux_gnd), .irq_o(irq));
  ////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] x);
    @(posedge ref_clk);
    addr <= a; wdata <= x; wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic wr_evt(input logic [3:0] a, input logic [15:0] x, input logic [12:0] e);
    @(posedge ref_clk);
    addr <= a; wdata <= x; wr <= 1'b1; pair_done <= e;
    @(posedge ref_clk);
    wr <= 1'b0; pair_done <= 13'h0000;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] x);
    @(posedge ref_clk);
    addr <= a; rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 x = rdata;
  endtask
  // Lowest set flag wins, index moved up two bits
  function automatic logic [15:0] exp_vec(input logic [15:0] bs, input logic [12:0] r);
    int idx;
    idx = 0;
    for (int i = 12; i >= 0; i--) if (r[i]) idx = i;
    return (bs & 16'hfffe) + 16'(idx << 2);
  endfunction
  task automatic wrap_up;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    wrap_up();
  end
  initial begin
    reset_n = 1'b0; addr = 4'h0; wdata = 16'h0000; wr = 1'b0; rd = 1'b0;
    pair_done = 13'h0000; rdy = 13'h0000; irqs = 13'h0000; b = 16'h0000;
    mismatches = 0; n_tests = 0;
    void'($urandom(32'hd86a));
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd_reg(A_ST, d); chk(d, 16'h0000);
    rd_reg(A_BASE, d); chk(d, 16'h0000);
    rd_reg(A_SEL, d); chk(d, 16'h0000);
    chk(pin_en | mux_gnd, 16'h0000);
    for (int k = 0; k < 30; k++) begin
      msk = (k == 0) ? 13'h0000 : 13'($urandom);
      wr_reg(A_MSK, {3'h0, msk});
      v = (k == 1) ? 13'h1fff : (k == 2) ? 13'h1000 : 13'($urandom);
      @(posedge ref_clk);
      pair_done <= v;
      @(posedge ref_clk);
      pair_done <= 13'h0000;
      #1 chk({3'h0, pair_irq}, {3'h0, v});
      rdy = rdy | v;
      irqs = irqs | v;
      b = (k == 3) ? 16'hffff : 16'($urandom);
      wr_reg(A_BASE, b);
      rd_reg(A_ST, d); chk(d, {3'h0, rdy});
      rd_reg(A_BASE, d); chk(d, exp_vec(b, rdy));
      chk({15'h0, irq}, {15'h0, |(irqs & msk)});
      rd_reg(A_IRQ, d); chk({3'h0, d[12:0]}, {3'h0, irqs});
      s = (k % 4 == 0) ? 16'h0000 : 16'($urandom);
      wr_reg(A_ST, s);
      rdy = rdy & s[12:0];
      rd_reg(A_BASE, d); chk(d, exp_vec(b, rdy));
      s = 16'($urandom);
      wr_reg(A_IRQ, s);
      irqs = irqs & ~s[12:0];
    end
    // Corner: an event beside a clearing write, the set wins
    wr_evt(A_ST, 16'h0000, 13'h1000);
    rd_reg(A_ST, d); chk(d, 16'h1000);
    rd_reg(A_BASE, d); chk(d, exp_vec(b, 13'h1000));
    wr_reg(A_IRQ, 16'hffff);
    wr_evt(A_IRQ, 16'hffff, 13'h0001);
    rd_reg(A_IRQ, d); chk(d, 16'h0001);
    rd_reg(A_BASE, d); chk(d, exp_vec(b, 13'h1001));
    for (int k = 0; k < 6; k++) begin
      s = (k == 0) ? 16'hffff : (k == 1) ? 16'h0000 : 16'($urandom);
      wr_reg(A_SEL, s);
      @(posedge ref_clk);
      #1 chk(pin_en, s);
      chk(mux_gnd, s);
      rd_reg(A_SEL, d); chk(d, s);
    end
    // Unmapped place: writes vanish, reads give zero
    wr_reg(4'hf, 16'hffff);
    rd_reg(4'hf, d); chk(d, 16'h0000);
    @(posedge ref_clk);
    #1 chk(rdata, 16'h0000);
    // Reset in mid-run brings every register back to zero
    wr_reg(A_SEL, 16'hffff);
    wr_reg(A_MSK, 16'h1fff);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd_reg(A_ST, d); chk(d, 16'h0000);
    rd_reg(A_BASE, d); chk(d, 16'h0000);
    rd_reg(A_SEL, d); chk(d, 16'h0000);
    chk(pin_en | mux_gnd, 16'h0000);
    chk({3'h0, pair_irq}, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    wrap_up();
  end
endmodule // adc_pair_ready_vector_portcfg_test
`default_nettype wire
